//--- src/ddc_pkg.sv
// Shared constants and types for the disk drive control input link.
package ddc_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_NS = 5;
   localparam int SETTLE_NS = 2000;
   localparam int STB_SETUP_NS = 500;
   localparam int STB_LOW_NS = 500;
   localparam int STB_HOLD_NS = 500;
   localparam int BUSY_MAX_NS = 1000;
   localparam int ERASE_GAP_NS = 4000;
   localparam int CNT_W = 10;
   typedef logic [CNT_W-1:0] ddc_cnt_t;
   // Least times round up to whole cycles.
   localparam ddc_cnt_t SETTLE_CNT =
      ddc_cnt_t'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
   localparam ddc_cnt_t STB_SETUP_CNT =
      ddc_cnt_t'((STB_SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam ddc_cnt_t STB_LOW_CNT =
      ddc_cnt_t'((STB_LOW_NS + CLK_NS - 1) / CLK_NS);
   localparam ddc_cnt_t STB_HOLD_CNT =
      ddc_cnt_t'((STB_HOLD_NS + CLK_NS - 1) / CLK_NS);
   localparam ddc_cnt_t ERASE_GAP_CNT =
      ddc_cnt_t'((ERASE_GAP_NS + CLK_NS - 1) / CLK_NS);
   localparam ddc_cnt_t CNT_ZERO = ddc_cnt_t'(0);
   localparam ddc_cnt_t CNT_ONE = ddc_cnt_t'(1);

   // ---------------------------------------------------------------
   // Cylinders and units
   // ---------------------------------------------------------------
   localparam int CYL_W = 9;
   typedef logic [CYL_W-1:0] ddc_cyl_t;
   localparam ddc_cyl_t CYL_HOME = 9'h000;
   localparam ddc_cyl_t CYL_LAST = 9'h195;
   localparam int UNITS = 4;

   // Raw pin levels, high is false on every line.
   typedef struct packed {
      logic [UNITS-1:0] unitSel;
      logic platter;
      logic platterExt;
      logic head;
      logic strobe;
      logic rtz;
      ddc_cyl_t cyl;
      logic write;
      logic erase;
      logic startStop;
   } ddc_pins_s;

   typedef enum logic [1:0] {DS_IDLE, DS_STROBE, DS_MOVE} ddc_drv_e;
   typedef enum logic [1:0] {CS_IDLE, CS_SETUP, CS_LOW, CS_HOLD} ddc_ctl_e;

   // ---------------------------------------------------------------
   // Controller register map
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CMD = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;
   localparam int CTRL_UNIT = 0;
   localparam int CTRL_PLATTER = 2;
   localparam int CTRL_EXT = 3;
   localparam int CTRL_HEAD = 4;
   localparam int CTRL_WRITE = 5;
   localparam int CTRL_ERASE = 6;
   localparam int CTRL_SS = 7;
   localparam int CMD_RTZ = 9;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- src/ddc_bus_if.sv
// Interface carrying the low-true control lines between both ends.
`timescale 1ns/10ps
`default_nettype none
interface ddc_bus_if;
   import ddc_pkg::*;
   // Controller-to-drive lines, all low-true.
   logic [UNITS-1:0] unitSelN;
   logic platterChoiceN;
   logic platterChoiceExtN;
   logic headChoiceN;
   logic cylStrobeN;
   logic returnToZeroN;
   ddc_cyl_t cylAddrN;
   logic writeGateN;
   logic eraseGateN;
   logic startStopN;
   // Drive outputs and the enable that attaches them to the bus.
   logic busySeekN;
   logic illegalCylN;
   logic readyN;
   logic drvOe;
   // Bus levels seen by the controller; an idle bus floats high.
   logic busySeekBus;
   logic illegalCylBus;
   logic readyBus;

   assign busySeekBus = drvOe ? busySeekN : 1'b1;
   assign illegalCylBus = drvOe ? illegalCylN : 1'b1;
   assign readyBus = drvOe ? readyN : 1'b1;

   modport drive (
      input unitSelN, platterChoiceN, platterChoiceExtN, headChoiceN,
      input cylStrobeN, returnToZeroN, cylAddrN, writeGateN,
      input eraseGateN, startStopN,
      output busySeekN, illegalCylN, readyN, drvOe
   );
   modport ctrl (
      output unitSelN, platterChoiceN, platterChoiceExtN, headChoiceN,
      output cylStrobeN, returnToZeroN, cylAddrN, writeGateN,
      output eraseGateN, startStopN,
      input busySeekBus, illegalCylBus, readyBus
   );
endinterface
`default_nettype wire

//--- src/ddc_drive.sv
// Drive end: decodes the low-true control lines into drive actions.
`timescale 1ns/10ps
`default_nettype none

module ddc_drive (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   ddc_bus_if.drive bus,
   input wire logic [1:0] unitNumber,
   input wire logic quadMode,
   input wire logic splitMode,
   input wire logic driveReady,
   input wire logic protUpper,
   input wire logic protFixed,
   input wire logic posDone,
   output logic posStart,
   output var ddc_pkg::ddc_cyl_t posTarget,
   output logic [2:0] headSel,
   output logic writeArmed,
   output logic readAllowed,
   output logic writeCurrent,
   output logic eraseCurrent,
   output logic remoteStartStop,
   output logic attached
);
   import ddc_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      ddc_pins_s sync1;
      ddc_pins_s sync2;
      logic strobePrev;
      ddc_cnt_t selCnt;
      ddc_drv_e st;
      logic rtz;
      logic overrun;
      logic busySeekN;
      logic illegalCylN;
      logic readyN;
      logic oe;
      logic posStart;
      ddc_cyl_t target;
      logic [2:0] head;
      logic wArm;
      logic rOk;
      logic wCur;
      logic eCur;
      logic ss;
   } ddc_drv_s;

   ddc_drv_s r_ff;
   ddc_drv_s nxt_r;
   ddc_pins_s pinsIn;
   ddc_pins_s p;
   logic [1:0] mateLine;
   logic mine;
   logic mate;
   logic sel;
   logic live;
   logic strobeFall;
   logic strobeRise;
   logic stationary;
   logic protHit;
   ddc_cyl_t cylValue;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Maps raw platter, extension and head levels onto a head number.
   function automatic logic [2:0] headCode(
      input logic quad,
      input logic split,
      input logic upperUnit,
      input logic platterLvl,
      input logic extLvl,
      input logic headLvl
   );
      logic topBit;
      topBit = 1'b0;
      if (quad && !split) begin
         topBit = !extLvl;
      end else if (split) begin
         topBit = upperUnit;
      end
      headCode = {topBit, platterLvl, headLvl};
   endfunction

   // Tells whether a seek target lies inside the cylinder range.
   function automatic logic cylLegal(input ddc_cyl_t cyl);
      cylLegal = (cyl <= CYL_LAST);
   endfunction

   // ---------------------------------------------------------------
   // Pin capture and selection
   // ---------------------------------------------------------------
   // Gathers the raw pin levels for the synchroniser.
   assign pinsIn = '{unitSel: bus.unitSelN,
                     platter: bus.platterChoiceN,
                     platterExt: bus.platterChoiceExtN,
                     head: bus.headChoiceN,
                     strobe: bus.cylStrobeN,
                     rtz: bus.returnToZeroN,
                     cyl: bus.cylAddrN,
                     write: bus.writeGateN,
                     erase: bus.eraseGateN,
                     startStop: bus.startStopN};

   // Decodes selection from the second synchroniser stage only.
   assign p = r_ff.sync2;
   assign mateLine = unitNumber + 2'h1;
   assign mine = !p.unitSel[unitNumber];
   assign mate = splitMode && !p.unitSel[mateLine];
   assign sel = mine || mate;
   assign live = sel && (r_ff.selCnt == SETTLE_CNT)
                 && driveReady;
   assign strobeFall = r_ff.strobePrev && !p.strobe;
   assign strobeRise = !r_ff.strobePrev && p.strobe;
   assign stationary = (r_ff.st != DS_MOVE);
   assign protHit = (r_ff.head[2:1] == 2'h0) ? protUpper : protFixed;
   assign cylValue = ~p.cyl;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   // Computes the whole next state; clock enable freezes it.
   always_comb begin
      nxt_r = r_ff;
      if (ce) begin
         nxt_r.sync1 = pinsIn;
         nxt_r.sync2 = r_ff.sync1;
         nxt_r.strobePrev = p.strobe;
         nxt_r.posStart = 1'b0;
         nxt_r.oe = sel;
         nxt_r.readyN = !driveReady;
         nxt_r.ss = !p.startStop;

         // Settle counter restarts whenever selection drops.
         if (!sel) begin
            nxt_r.selCnt = CNT_ZERO;
         end else if (r_ff.selCnt != SETTLE_CNT) begin
            nxt_r.selCnt = r_ff.selCnt + CNT_ONE;
         end

         // An ignored strobe flags illegal at its rise, even after the move.
         if (r_ff.overrun && strobeRise) begin
            nxt_r.illegalCylN = 1'b0;
            nxt_r.overrun = 1'b0;
         end

         // Positioning command sequence.
         case (r_ff.st)
            DS_IDLE: begin
               if (live && strobeFall) begin
                  nxt_r.st = DS_STROBE;
                  nxt_r.busySeekN = 1'b0;
                  nxt_r.illegalCylN = 1'b1;
                  nxt_r.rtz = !p.rtz;
               end
            end
            DS_STROBE: begin
               if (!sel) begin
                  nxt_r.st = DS_IDLE;
                  nxt_r.busySeekN = 1'b1;
               end else if (strobeRise) begin
                  if (r_ff.rtz) begin
                     nxt_r.target = CYL_HOME;
                     nxt_r.posStart = 1'b1;
                     nxt_r.st = DS_MOVE;
                  end else if (cylLegal(cylValue)) begin
                     nxt_r.target = cylValue;
                     nxt_r.posStart = 1'b1;
                     nxt_r.st = DS_MOVE;
                  end else begin
                     nxt_r.illegalCylN = 1'b0;
                     nxt_r.busySeekN = 1'b1;
                     nxt_r.st = DS_IDLE;
                  end
               end
            end
            DS_MOVE: begin
               // A strobe during a move is remembered, not obeyed.
               if (live && strobeFall) begin
                  nxt_r.overrun = 1'b1;
               end
               if (posDone) begin
                  nxt_r.st = DS_IDLE;
                  nxt_r.busySeekN = 1'b1;
               end
            end
            default: begin
               nxt_r.st = DS_IDLE;
            end
         endcase

         // Head decode and write/erase gating while live.
         if (live) begin
            nxt_r.head = headCode(quadMode, splitMode, mate && !mine,
                                  p.platter, p.platterExt, p.head);
         end
         nxt_r.wArm = live && !p.write;
         nxt_r.rOk = live && p.write;
         nxt_r.wCur = live && !p.write && !protHit
                      && stationary;
         nxt_r.eCur = live && !p.erase && !protHit
                      && stationary;
      end
      if (rst) begin
         nxt_r = '0;
         nxt_r.sync1 = '1;
         nxt_r.sync2 = '1;
         nxt_r.strobePrev = 1'b1;
         nxt_r.busySeekN = 1'b1;
         nxt_r.illegalCylN = 1'b1;
         nxt_r.readyN = 1'b1;
         nxt_r.st = DS_IDLE;
      end
   end

   // Registers the whole state.
   always_ff @(posedge clock) begin
      r_ff <= nxt_r;
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Every output is a state bit.
   assign bus.busySeekN = r_ff.busySeekN;
   assign bus.illegalCylN = r_ff.illegalCylN;
   assign bus.readyN = r_ff.readyN;
   assign bus.drvOe = r_ff.oe;
   assign posStart = r_ff.posStart;
   assign posTarget = r_ff.target;
   assign headSel = r_ff.head;
   assign writeArmed = r_ff.wArm;
   assign readAllowed = r_ff.rOk;
   assign writeCurrent = r_ff.wCur;
   assign eraseCurrent = r_ff.eCur;
   assign remoteStartStop = r_ff.ss;
   assign attached = r_ff.oe;

endmodule
`default_nettype wire

//--- src/ddc_ctrl.sv
// Controller end: AXI4-Lite registers driving the control lines.
`timescale 1ns/10ps
`default_nettype none
module ddc_ctrl (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   ddc_bus_if.ctrl bus,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   import ddc_pkg::*;

   typedef struct packed {
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic [7:0] ctl;
      logic rtz;
      ddc_cyl_t cyl;
      ddc_ctl_e st;
      ddc_cnt_t cnt;
      ddc_cnt_t settle;
      ddc_cnt_t eraseCnt;
      logic refused;
      logic [UNITS-1:0] unitSelN;
      logic writeN;
      logic eraseN;
      logic strobeN;
      logic awHeld;
      logic [7:0] awAddr;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic awRdy;
      logic wRdy;
      logic bValid;
      logic [1:0] bResp;
      logic arRdy;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } ddc_ctl_s;

   ddc_ctl_s r_ff;
   ddc_ctl_s nxt_r;
   logic busy;
   logic settled;
   logic [31:0] status;
   logic [31:0] ctlMerged;
   logic [31:0] cmdMerged;

   // Merges written bytes into an old register value.
   function automatic logic [31:0] merge(
      input logic [31:0] old,
      input logic [31:0] data,
      input logic [3:0] strb
   );
      logic [31:0] mask;
      mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      merge = (old & ~mask) | (data & mask);
   endfunction

   // Drive status comes from the second synchroniser stage.
   assign busy = !r_ff.sync2[0];
   assign settled = (r_ff.settle == SETTLE_CNT);
   assign status = {27'h0000000, r_ff.refused, r_ff.st != CS_IDLE,
                    !r_ff.sync2[2], !r_ff.sync2[1], busy};

   // Byte-merged write values for the two writable registers.
   assign ctlMerged = merge({24'h000000, r_ff.ctl},
                            r_ff.wData, r_ff.wStrb);
   assign cmdMerged = merge({22'h000000, r_ff.rtz, r_ff.cyl},
                            r_ff.wData, r_ff.wStrb);

   // Computes the next state of bus slave, lines and strobe sequence.
   always_comb begin
      nxt_r = r_ff;
      if (ce) begin
         nxt_r.sync1 = {bus.readyBus, bus.illegalCylBus, bus.busySeekBus};
         nxt_r.sync2 = r_ff.sync1;
         if (awvalid && r_ff.awRdy) begin
            nxt_r.awHeld = 1'b1;
            nxt_r.awAddr = awaddr;
         end
         if (wvalid && r_ff.wRdy) begin
            nxt_r.wHeld = 1'b1;
            nxt_r.wData = wdata;
            nxt_r.wStrb = wstrb;
         end
         if (r_ff.bValid && bready) begin
            nxt_r.bValid = 1'b0;
         end
         // A write completes once address and data are both held.
         if (r_ff.awHeld && r_ff.wHeld && !r_ff.bValid) begin
            nxt_r.awHeld = 1'b0;
            nxt_r.wHeld = 1'b0;
            nxt_r.bValid = 1'b1;
            nxt_r.bResp = RESP_OKAY;
            if (r_ff.awAddr == REG_CTRL) begin
               nxt_r.ctl = ctlMerged[7:0];
            end else if (r_ff.awAddr == REG_CMD) begin
               if (r_ff.st != CS_IDLE || busy || !settled) begin
                  nxt_r.refused = 1'b1;
               end else begin
                  {nxt_r.rtz, nxt_r.cyl} = cmdMerged[CMD_RTZ:0];
                  nxt_r.refused = 1'b0;
                  nxt_r.st = CS_SETUP;
                  nxt_r.cnt = CNT_ZERO;
               end
            end else if (r_ff.awAddr != REG_STAT) begin
               nxt_r.bResp = RESP_SLVERR;
            end
         end
         if (r_ff.rValid && rready) begin
            nxt_r.rValid = 1'b0;
         end
         // Reads answer the cycle after the address is taken.
         if (arvalid && r_ff.arRdy) begin
            nxt_r.rValid = 1'b1;
            nxt_r.rResp = RESP_OKAY;
            nxt_r.rData = 32'h00000000;
            case (araddr)
               REG_CTRL: nxt_r.rData = {24'h000000, r_ff.ctl};
               REG_CMD: nxt_r.rData = {22'h000000, r_ff.rtz, r_ff.cyl};
               REG_STAT: nxt_r.rData = status;
               default: nxt_r.rResp = RESP_SLVERR;
            endcase
         end
         nxt_r.awRdy = !nxt_r.awHeld && !nxt_r.bValid;
         nxt_r.wRdy = !nxt_r.wHeld && !nxt_r.bValid;
         nxt_r.arRdy = !nxt_r.rValid;

         // Unit select lines; a change restarts the settle wait.
         nxt_r.unitSelN = ~(UNITS'(1) << r_ff.ctl[CTRL_UNIT +: 2]);
         if (nxt_r.unitSelN != r_ff.unitSelN) begin
            nxt_r.settle = CNT_ZERO;
         end else if (!settled) begin
            nxt_r.settle = r_ff.settle + CNT_ONE;
         end

         // Erase falls with write and outlasts it by the gap.
         nxt_r.writeN = !r_ff.ctl[CTRL_WRITE];
         if (r_ff.ctl[CTRL_WRITE]) begin
            nxt_r.eraseN = 1'b0;
            nxt_r.eraseCnt = ERASE_GAP_CNT;
         end else if (r_ff.eraseCnt != CNT_ZERO) begin
            nxt_r.eraseN = 1'b0;
            nxt_r.eraseCnt = r_ff.eraseCnt - CNT_ONE;
         end else begin
            nxt_r.eraseN = !r_ff.ctl[CTRL_ERASE];
         end

         // Strobe sequence: setup, low time, hold.
         nxt_r.cnt = r_ff.cnt + CNT_ONE;
         case (r_ff.st)
            CS_IDLE: nxt_r.cnt = CNT_ZERO;
            CS_SETUP: begin
               if (r_ff.cnt == STB_SETUP_CNT) begin
                  nxt_r.st = CS_LOW;
                  nxt_r.strobeN = 1'b0;
                  nxt_r.cnt = CNT_ZERO;
               end
            end
            CS_LOW: begin
               if (r_ff.cnt == STB_LOW_CNT) begin
                  nxt_r.st = CS_HOLD;
                  nxt_r.strobeN = 1'b1;
                  nxt_r.cnt = CNT_ZERO;
               end
            end
            CS_HOLD: begin
               if (r_ff.cnt == STB_HOLD_CNT) begin
                  nxt_r.st = CS_IDLE;
               end
            end
            default: nxt_r.st = CS_IDLE;
         endcase
      end
      if (rst) begin
         nxt_r = '0;
         nxt_r.sync1 = '1;
         nxt_r.sync2 = '1;
         nxt_r.ctl = CTRL_RST;
         nxt_r.unitSelN = '1;
         nxt_r.writeN = 1'b1;
         nxt_r.eraseN = 1'b1;
         nxt_r.strobeN = 1'b1;
         nxt_r.st = CS_IDLE;
      end
   end

   // Registers the whole state.
   always_ff @(posedge clock) begin
      r_ff <= nxt_r;
   end

   // Lines are driven low-true straight from state.
   assign bus.unitSelN = r_ff.unitSelN;
   assign bus.platterChoiceN = !r_ff.ctl[CTRL_PLATTER];
   assign bus.platterChoiceExtN = !r_ff.ctl[CTRL_EXT];
   assign bus.headChoiceN = !r_ff.ctl[CTRL_HEAD];
   assign bus.cylStrobeN = r_ff.strobeN;
   assign bus.returnToZeroN = !r_ff.rtz;
   assign bus.cylAddrN = ~r_ff.cyl;
   assign bus.writeGateN = r_ff.writeN;
   assign bus.eraseGateN = r_ff.eraseN;
   assign bus.startStopN = !r_ff.ctl[CTRL_SS];
   assign awready = r_ff.awRdy;
   assign wready = r_ff.wRdy;
   assign bresp = r_ff.bResp;
   assign bvalid = r_ff.bValid;
   assign arready = r_ff.arRdy;
   assign rdata = r_ff.rData;
   assign rresp = r_ff.rResp;
   assign rvalid = r_ff.rValid;

endmodule
`default_nettype wire

//--- test/ddc_link_monitor.sv
// Checker on the low-true lines between controller and drive.
`timescale 1ns/10ps
`default_nettype none
module ddc_link_monitor
   import ddc_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [UNITS-1:0] unitSelN,
   input wire logic cylStrobeN,
   input wire logic returnToZeroN,
   input wire ddc_pkg::ddc_cyl_t cylAddrN,
   input wire logic writeGateN,
   input wire logic eraseGateN,
   input wire logic busySeekN,
   input wire logic illegalCylN,
   input wire logic drvOe
);
   // ----
   // Helper
   // ----
   logic [9:0] wgHigh_ff;
   // Counts cycles since the write gate went false.
   always_ff @(posedge clock) begin
      if (rst || !writeGateN) begin
         wgHigh_ff <= 10'h000;
      end else if (wgHigh_ff != 10'h3FF) begin
         wgHigh_ff <= wgHigh_ff + 10'h001;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Properties on each line relation.
   property p_busy;
      $fell(cylStrobeN) && drvOe |-> ##[1:200] !busySeekN;
   endproperty
   property p_width;
      $fell(cylStrobeN) |-> ##100 !cylStrobeN ##1 cylStrobeN;
   endproperty
   property p_stable;
      !cylStrobeN |-> $stable(cylAddrN) && $stable(returnToZeroN);
   endproperty
   property p_oeOn;
      !unitSelN[0] [*4] |-> drvOe;
   endproperty
   property p_oeOff;
      unitSelN[0] [*4] |-> !drvOe;
   endproperty
   property p_noBusy;
      $fell(cylStrobeN) && drvOe |-> busySeekN;
   endproperty
   property p_bad;
      $rose(cylStrobeN) && drvOe && returnToZeroN && ~cylAddrN > CYL_LAST
         |-> ##[2:4] !illegalCylN;
   endproperty
   property p_good;
      $rose(cylStrobeN) && drvOe && (!returnToZeroN || ~cylAddrN <= CYL_LAST)
         |-> ##1 illegalCylN [*4];
   endproperty
   property p_gap;
      $rose(eraseGateN) |-> wgHigh_ff >= ERASE_GAP_CNT;
   endproperty
   property p_wrEr;
      $fell(writeGateN) |-> !eraseGateN;
   endproperty
   a_busy: assert property (p_busy)
      else $error("busy late");
   a_width: assert property (p_width)
      else $error("strobe width");
   a_stable: assert property (p_stable)
      else $error("lines moved in strobe");
   a_oeOn: assert property (p_oeOn)
      else $error("not attached");
   a_oeOff: assert property (p_oeOff)
      else $error("attached unselected");
   a_noBusy: assert property (p_noBusy)
      else $error("strobe while busy");
   a_bad: assert property (p_bad)
      else $error("illegal not flagged");
   a_good: assert property (p_good)
      else $error("false illegal");
   a_gap: assert property (p_gap)
      else $error("erase gap short");
   a_wrEr: assert property (p_wrEr)
      else $error("erase late");
   c_bad: cover property ($fell(illegalCylN));
   c_home: cover property ($rose(cylStrobeN) && !returnToZeroN);
   c_gap: cover property ($rose(eraseGateN));
endmodule
`default_nettype wire

//--- test/ddc_tb_top.sv
// Self-checking bench joining the controller and drive ends.
`timescale 1ns/10ps
`default_nettype none
module ddc_tb_top;
   import ddc_pkg::*;
   // ----
   // Signals
   // ----
   logic clock, rst, posDone, protUpper, protFixed, quadMode;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, posStart, writeArmed;
   logic readAllowed, writeCurrent, eraseCurrent, remoteStartStop, attached;
   ddc_cyl_t posTarget;
   logic [31:0] rdWord;
   logic [2:0] headSel;
   int errTotal, checkCount, cycles;
   ddc_bus_if ddc_bus_if_inst ();
   ddc_drive ddc_drive_inst (.clock, .rst, .ce(1'b1),
      .bus(ddc_bus_if_inst), .unitNumber(2'h0), .quadMode,
      .splitMode(1'b0), .driveReady(1'b1), .protUpper, .protFixed,
      .posDone, .posStart, .posTarget, .headSel, .writeArmed,
      .readAllowed, .writeCurrent, .eraseCurrent, .remoteStartStop,
      .attached);
   ddc_ctrl ddc_ctrl_inst (.clock, .rst, .ce(1'b1),
      .bus(ddc_bus_if_inst), .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
   ddc_link_monitor ddc_link_monitor_inst (.clock, .rst,
      .unitSelN(ddc_bus_if_inst.unitSelN),
      .cylStrobeN(ddc_bus_if_inst.cylStrobeN),
      .returnToZeroN(ddc_bus_if_inst.returnToZeroN),
      .cylAddrN(ddc_bus_if_inst.cylAddrN),
      .writeGateN(ddc_bus_if_inst.writeGateN),
      .eraseGateN(ddc_bus_if_inst.eraseGateN),
      .busySeekN(ddc_bus_if_inst.busySeekN),
      .illegalCylN(ddc_bus_if_inst.illegalCylN),
      .drvOe(ddc_bus_if_inst.drvOe));
   // ----
   // Tasks
   // ----
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checkCount++;
      if (s !== e) begin
         errTotal++;
         $display("wrong value %s exp %h seen %h", n, e, s);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      {awaddr, wdata, wstrb} <= {a, d, 4'hF};
      {awvalid, wvalid, bready} <= 3'h7;
      do begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      rready <= 1'b0;
   endtask
   task seek(input logic [31:0] c, input logic [31:0] e);
      int n;
      n = 0;
      wr(8'h04, c);
      wr(8'h04, 32'h0);
      rd(REG_STAT, rdWord);
      chk("refused", rdWord[4:3], 32'h3);
      while (posStart !== 1'b1 && n < 600) begin
         @(posedge clock);
         n++;
      end
      chk("posStart", posStart, 1);
      chk("posTarget", posTarget, e);
      chk("strobe", ddc_bus_if_inst.cylStrobeN, 1);
      posDone <= 1'b1;
      tick(1);
      posDone <= 1'b0;
      tick(4);
      chk("busy", ddc_bus_if_inst.busySeekBus, 1);
      tick(100);
   endtask
   task wrapUp;
      if (errTotal == 0 && checkCount > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Clock of 5 ns.
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // Hang guard.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         errTotal++;
         wrapUp();
      end
   end
   // Main sequence.
   initial begin
      {rst, posDone, protUpper, protFixed, quadMode} <= 5'h10;
      {awvalid, wvalid, bready, arvalid, rready} <= 5'h0;
      {awaddr, araddr, wdata, wstrb} <= '0;
      tick(4);
      rst <= 1'b0;
      tick(2);
      chk("rstOe", attached, 0);
      chk("rstBusy", ddc_bus_if_inst.busySeekN, 1);
      wr(8'h00, 32'h81);
      tick(10);
      chk("remote", remoteStartStop, 1);
      chk("attach", attached, 0);
      wr(REG_CTRL, 32'h0);
      tick(SETTLE_CNT + 10);
      for (int i = 0; i < 16; i++) begin
         quadMode <= i[3];
         wr(8'h00, {27'h0, i[2:0], 2'h0});
         tick(8);
         chk("head", headSel, {i[3] & i[1], !i[0], !i[2]});
      end
      chk("attach", attached, 1);
      seek(32'h195, 32'h195);
      wr(8'h04, 32'h196);
      tick(310);
      chk("bad", ddc_bus_if_inst.illegalCylBus, 0);
      rd(REG_STAT, rdWord);
      chk("stat", rdWord, 32'h6);
      seek(32'h3FF, 32'h0);
      chk("clear", ddc_bus_if_inst.illegalCylBus, 1);
      quadMode <= 1'b0;
      protFixed <= 1'b1;
      wr(8'h00, 32'h64);
      tick(10);
      chk("wrCur", writeCurrent, 1);
      chk("erCur", eraseCurrent, 1);
      chk("rdOff", readAllowed, 0);
      chk("wrArm", writeArmed, 1);
      protUpper <= 1'b1;
      tick(6);
      chk("prot", writeCurrent, 0);
      chk("protEr", eraseCurrent, 0);
      wr(8'h00, 32'h04);
      tick(900);
      wrapUp();
   end
endmodule
`default_nettype wire
